// ==== hw/eeprom_slave_pkg.sv ====
// constants, field layouts and state encoding for the two-wire eeprom slave front end
package eeprom_slave_pkg;

	// ----------------------------------------------------------------
	// identity
	// ----------------------------------------------------------------
	// device-type code; value is arbitrary
	localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

	// ----------------------------------------------------------------
	// widths and geometry
	// ----------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int PAGE_W     = 8;
	localparam int BYTE_W     = 5;
	localparam int ADDR_W     = PAGE_W + BYTE_W;
	localparam int FIFO_W     = PAGE_W + BYTE_W + DATA_W;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W      = 4;
	localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// slave address byte fields
	// ----------------------------------------------------------------
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int SEL_MSB  = 3;
	localparam int SEL_LSB  = 1;
	localparam int DIR_BIT  = 0;
	localparam logic DIR_READ = 1'b1;

	// ----------------------------------------------------------------
	// word address fields
	// ----------------------------------------------------------------
	localparam int HI_PAGE_MSB = 4;
	localparam int LO_PAGE_MSB = 7;
	localparam int LO_PAGE_LSB = 5;
	localparam int LO_BYTE_MSB = 4;

	// ----------------------------------------------------------------
	// block protect codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] BP_NONE    = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF    = 2'h2;
	localparam logic [1:0] BP_ALL     = 2'h3;
	localparam logic       WEL_RST    = 1'b0;
	localparam logic       LOCK_RST   = 1'b0;
	localparam logic [1:0] BP_RST     = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_ACK, ST_TX, ST_RACK
	} link_state_t;

endpackage

// ==== hw/data_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module data_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,       // system clock
	input  wire logic             rst,       // async reset, high
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // space available
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // reader takes word
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      cnt_r;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != FULL_CNT);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_ptr_r];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	// storage needs no reset; occupancy is tracked by the counter
	always_ff @(posedge clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

endmodule

// ==== hw/eeprom_two_wire_slave.sv ====
// two-wire eeprom slave front end: framing, addressing, acknowledge and write gating
`timescale 1ns/10ps
module eeprom_two_wire_slave (
	input  wire logic        clk,                // system clock, 125 MHz
	input  wire logic        rst,                // async reset, high
	input  wire logic        scl_pin,            // serial clock from master
	input  wire logic        sda_pin_i,          // serial data line level
	output logic             sda_pin_o,          // serial data output value
	output logic             sda_pin_oe,         // high while pulling data low
	input  wire logic        select_pin_0,       // device select pin 0
	input  wire logic        select_pin_1,       // device select pin 1
	input  wire logic        select_pin_2,       // device select pin 2
	input  wire logic        write_protect_pin,  // hardware write protect pin
	input  wire logic        nv_busy,            // nonvolatile cycle running
	input  wire logic        wel_set,            // set write-enable latch
	input  wire logic        wel_clr,            // clear write-enable latch
	input  wire logic        prot_wr,            // request protect bits update
	input  wire logic [1:0]  prot_bp,            // new block-protect value
	input  wire logic        prot_lock,          // new lock-enable value
	output logic             write_enable_latch, // latch state
	output logic             protect_lock_enable,// lock state
	output logic             block_protect_bit0, // block-protect bit 0
	output logic             block_protect_bit1, // block-protect bit 1
	output logic             prot_refused,       // protect update refused, pulse
	output logic             wr_valid,           // write byte available
	input  wire logic        wr_ready,           // write byte taken
	output logic [7:0]       wr_page,            // page of write byte
	output logic [4:0]       wr_byte,            // byte within page
	output logic [7:0]       wr_data,            // write byte value
	output logic             wr_dropped,         // byte dropped, latch clear or region protected, pulse
	output logic [12:0]      rd_addr,            // address of next read byte
	input  wire logic [7:0]  rd_data,            // array content at rd_addr
	output logic             rd_req,             // read byte consumed, pulse
	output logic             link_active         // addressed and in a transfer
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic       scl_s1_r;
	logic       scl_s2_r;
	logic       scl_d_r;
	logic       sda_s1_r;
	logic       sda_s2_r;
	logic       sda_d_r;
	logic [2:0] sel_s1_r;
	logic [2:0] sel_s2_r;
	logic       wp_s1_r;
	logic       wp_s2_r;

	// only the second stage and its delayed copy feed any logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
			sel_s1_r <= 3'h0;
			sel_s2_r <= 3'h0;
			wp_s1_r  <= 1'b0;
			wp_s2_r  <= 1'b0;
		end else begin
			scl_s1_r <= scl_pin;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_pin_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
			sel_s1_r <= {select_pin_2, select_pin_1, select_pin_0};
			sel_s2_r <= sel_s1_r;
			wp_s1_r  <= write_protect_pin;
			wp_s2_r  <= wp_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	wire scl_rise  = scl_s2_r & ~scl_d_r;
	wire scl_fall  = ~scl_s2_r & scl_d_r;
	wire scl_high  = scl_s2_r & scl_d_r;
	// data edges with clock steady high are framing, not data
	wire start_det = scl_high & sda_d_r & ~sda_s2_r;
	wire stop_det  = scl_high & ~sda_d_r & sda_s2_r;

	// ----------------------------------------------------------------
	// protection state
	// ----------------------------------------------------------------
	logic       wel_r;
	logic       lock_r;
	logic [1:0] bp_r;
	logic       prot_refused_r;

	// region guarded by the block-protect code, counted from the top
	function automatic logic region_locked(input logic [1:0] bp, input logic [12:0] a);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			eeprom_slave_pkg::BP_NONE:    hit = 1'b0;
			eeprom_slave_pkg::BP_QUARTER: hit = (a[12:11] == 2'h3);
			eeprom_slave_pkg::BP_HALF:    hit = a[12];
			eeprom_slave_pkg::BP_ALL:     hit = 1'b1;
		endcase
		return hit;
	endfunction

	// pin high with lock set freezes the protect bits
	wire hw_protect   = wp_s2_r & lock_r;
	wire prot_take    = prot_wr & wel_r & ~hw_protect;
	wire prot_reject  = prot_wr & ~prot_take;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wel_r          <= eeprom_slave_pkg::WEL_RST;
			lock_r         <= eeprom_slave_pkg::LOCK_RST;
			bp_r           <= eeprom_slave_pkg::BP_RST;
			prot_refused_r <= 1'b0;
		end else begin
			if (wel_set)
				wel_r <= 1'b1;
			else if (wel_clr)
				wel_r <= 1'b0;
			if (prot_take) begin
				bp_r   <= prot_bp;
				lock_r <= prot_lock;
			end
			prot_refused_r <= prot_reject;
		end
	end

	assign write_enable_latch  = wel_r;
	assign protect_lock_enable = lock_r;
	assign block_protect_bit0  = bp_r[0];
	assign block_protect_bit1  = bp_r[1];
	assign prot_refused        = prot_refused_r;

	// ----------------------------------------------------------------
	// link state
	// ----------------------------------------------------------------
	eeprom_slave_pkg::link_state_t state_r, state_nxt, follow_r, follow_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [7:0]  shift_r, shift_nxt;
	logic [7:0]  hi_r, hi_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic        drive_low_r, drive_low_nxt;
	logic        mack_r, mack_nxt;
	logic        rd_req_r;
	logic        wr_dropped_r;

	wire         byte_done  = (cnt_r == eeprom_slave_pkg::BITS_PER_BYTE);
	wire         rx_state   = (state_r == eeprom_slave_pkg::ST_DEV) |
	                          (state_r == eeprom_slave_pkg::ST_AHI) |
	                          (state_r == eeprom_slave_pkg::ST_ALO) |
	                          (state_r == eeprom_slave_pkg::ST_WDAT);
	wire         rx_sample  = rx_state & scl_rise & ~byte_done;
	wire         rx_decide  = rx_state & scl_fall & byte_done;

	// slave address decode
	wire [3:0]   type_bits  = shift_r[eeprom_slave_pkg::TYPE_MSB:eeprom_slave_pkg::TYPE_LSB];
	wire [2:0]   sel_bits   = shift_r[eeprom_slave_pkg::SEL_MSB:eeprom_slave_pkg::SEL_LSB];
	wire         dir_read   = (shift_r[eeprom_slave_pkg::DIR_BIT] == eeprom_slave_pkg::DIR_READ);
	wire         dev_match  = (type_bits == eeprom_slave_pkg::DEV_TYPE_CODE) &
	                          (sel_bits == sel_s2_r);
	wire         addr_ack   = dev_match & ~nv_busy;

	// page from high byte and top of low byte, byte from the rest
	wire [7:0]   page_sel   = {hi_r[eeprom_slave_pkg::HI_PAGE_MSB:0],
	                           shift_r[eeprom_slave_pkg::LO_PAGE_MSB:eeprom_slave_pkg::LO_PAGE_LSB]};
	wire [4:0]   byte_sel   = shift_r[eeprom_slave_pkg::LO_BYTE_MSB:0];

	// incoming data byte: space in the buffer decides the acknowledge
	logic        fifo_in_ready;
	wire         wdat_end   = (state_r == eeprom_slave_pkg::ST_WDAT) & rx_decide;
	wire         wr_allowed = wel_r & ~region_locked(bp_r, addr_r);
	wire         fifo_push  = wdat_end & fifo_in_ready & wr_allowed;
	wire         drop_byte  = wdat_end & fifo_in_ready & ~wr_allowed;
	// write pointer wraps inside the current page
	wire [4:0]   byte_inc   = addr_r[4:0] + 5'h01;

	// a new byte is loaded after the address ack or after a master ack
	wire         load_tx    = scl_fall &
	                          (((state_r == eeprom_slave_pkg::ST_ACK) &
	                            (follow_r == eeprom_slave_pkg::ST_TX)) |
	                           ((state_r == eeprom_slave_pkg::ST_RACK) & mack_r));

	always_comb begin
		state_nxt     = state_r;
		follow_nxt    = follow_r;
		cnt_nxt       = cnt_r;
		shift_nxt     = shift_r;
		hi_nxt        = hi_r;
		addr_nxt      = addr_r;
		drive_low_nxt = drive_low_r;
		mack_nxt      = mack_r;
		if (stop_det) begin
			state_nxt     = eeprom_slave_pkg::ST_IDLE;
			drive_low_nxt = 1'b0;
		end else if (start_det) begin
			state_nxt     = eeprom_slave_pkg::ST_DEV;
			cnt_nxt       = 4'h0;
			drive_low_nxt = 1'b0;
		end else begin
			unique case (state_r)
				eeprom_slave_pkg::ST_IDLE: begin
					drive_low_nxt = 1'b0;
				end
				eeprom_slave_pkg::ST_DEV, eeprom_slave_pkg::ST_AHI,
				eeprom_slave_pkg::ST_ALO, eeprom_slave_pkg::ST_WDAT: begin
					if (rx_sample) begin
						shift_nxt = {shift_r[6:0], sda_s2_r};
						cnt_nxt   = cnt_r + 4'h1;
					end else if (rx_decide) begin
						// ack is asserted just after the eighth falling edge
						drive_low_nxt = 1'b1;
						state_nxt     = eeprom_slave_pkg::ST_ACK;
						unique case (state_r)
							eeprom_slave_pkg::ST_DEV: begin
								follow_nxt = dir_read ? eeprom_slave_pkg::ST_TX
								                      : eeprom_slave_pkg::ST_AHI;
								if (!addr_ack) begin
									drive_low_nxt = 1'b0;
									state_nxt     = eeprom_slave_pkg::ST_IDLE;
								end
							end
							eeprom_slave_pkg::ST_AHI: begin
								hi_nxt     = shift_r;
								follow_nxt = eeprom_slave_pkg::ST_ALO;
							end
							eeprom_slave_pkg::ST_ALO: begin
								addr_nxt   = {page_sel, byte_sel};
								follow_nxt = eeprom_slave_pkg::ST_WDAT;
							end
							default: begin
								follow_nxt = eeprom_slave_pkg::ST_WDAT;
								addr_nxt   = {addr_r[12:5], byte_inc};
								if (!fifo_in_ready) begin
									// full buffer: withhold ack and return to idle
									drive_low_nxt = 1'b0;
									state_nxt     = eeprom_slave_pkg::ST_IDLE;
									addr_nxt      = addr_r;
								end
							end
						endcase
					end
				end
				eeprom_slave_pkg::ST_ACK: begin
					if (scl_fall) begin
						drive_low_nxt = 1'b0;
						cnt_nxt       = 4'h0;
						state_nxt     = follow_r;
					end
				end
				eeprom_slave_pkg::ST_TX: begin
					if (scl_fall) begin
						if (byte_done) begin
							drive_low_nxt = 1'b0;
							state_nxt     = eeprom_slave_pkg::ST_RACK;
						end else begin
							drive_low_nxt = ~shift_r[6];
							shift_nxt     = {shift_r[6:0], 1'b0};
							cnt_nxt       = cnt_r + 4'h1;
						end
					end
				end
				eeprom_slave_pkg::ST_RACK: begin
					if (scl_rise)
						mack_nxt = ~sda_s2_r;
					else if (scl_fall && !mack_r) begin
						drive_low_nxt = 1'b0;
						state_nxt     = eeprom_slave_pkg::ST_IDLE;
					end
				end
			endcase
			if (load_tx) begin
				// first bit goes out on the same falling edge that ends the ack
				shift_nxt     = rd_data;
				drive_low_nxt = ~rd_data[7];
				cnt_nxt       = 4'h1;
				state_nxt     = eeprom_slave_pkg::ST_TX;
				mack_nxt      = 1'b0;
				addr_nxt      = addr_r + 13'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r      <= eeprom_slave_pkg::ST_IDLE;
			follow_r     <= eeprom_slave_pkg::ST_IDLE;
			cnt_r        <= 4'h0;
			shift_r      <= 8'h00;
			hi_r         <= 8'h00;
			addr_r       <= 13'h0000;
			drive_low_r  <= 1'b0;
			mack_r       <= 1'b0;
			rd_req_r     <= 1'b0;
			wr_dropped_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			follow_r     <= follow_nxt;
			cnt_r        <= cnt_nxt;
			shift_r      <= shift_nxt;
			hi_r         <= hi_nxt;
			addr_r       <= addr_nxt;
			drive_low_r  <= drive_low_nxt;
			mack_r       <= mack_nxt;
			rd_req_r     <= load_tx;
			wr_dropped_r <= drop_byte;
		end
	end

	// ----------------------------------------------------------------
	// pins and user side
	// ----------------------------------------------------------------
	// never drives high and never touches the clock line
	assign sda_pin_o   = 1'b0;
	assign sda_pin_oe  = drive_low_r;
	assign rd_addr     = addr_r;
	assign rd_req      = rd_req_r;
	assign wr_dropped  = wr_dropped_r;
	assign link_active = (state_r != eeprom_slave_pkg::ST_IDLE) &
	                     (state_r != eeprom_slave_pkg::ST_DEV);

	logic [eeprom_slave_pkg::FIFO_W-1:0] fifo_out;

	data_fifo #(
		.WIDTH (eeprom_slave_pkg::FIFO_W),
		.DEPTH (eeprom_slave_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({addr_r, shift_r}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (fifo_out)
	);

	assign wr_page = fifo_out[20:13];
	assign wr_byte = fifo_out[12:8];
	assign wr_data = fifo_out[7:0];

endmodule

// ==== verification/eeprom_slave_chk.sv ====
// port-level checks for the two-wire eeprom slave
`timescale 1ns/10ps
module eeprom_slave_chk (
	input wire logic       clk,                 // clock
	input wire logic       rst,                 // reset
	input wire logic       scl_pin,             // clock pin
	input wire logic       sda_pin_o,           // data value
	input wire logic       sda_pin_oe,          // data pull
	input wire logic       write_protect_pin,   // wp pin
	input wire logic       wel_set,             // latch set
	input wire logic       prot_wr,             // protect load
	input wire logic [1:0] prot_bp,             // new bp
	input wire logic       prot_lock,           // new lock
	input wire logic       write_enable_latch,  // latch
	input wire logic       protect_lock_enable, // lock
	input wire logic       block_protect_bit0,  // bp0
	input wire logic       block_protect_bit1,  // bp1
	input wire logic       prot_refused,        // refusal
	input wire logic       wr_valid,            // head valid
	input wire logic       wr_ready,            // pop
	input wire logic [7:0] wr_data,             // head data
	input wire logic       rd_req               // read pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_od_never_high: assert property (sda_pin_o == 1'b0)
		else $error("data driven high");
	a_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !$past(scl_pin))
		else $error("data moved with clock high");
	a_latch_set: assert property (wel_set |=> write_enable_latch)
		else $error("latch not set");
	a_refuse_nolatch: assert property (prot_wr && !write_enable_latch |=> prot_refused)
		else $error("update taken without latch");
	a_refuse_locked: assert property (
		prot_wr && write_protect_pin && protect_lock_enable |=> prot_refused)
		else $error("locked update taken");
	a_prot_load: assert property (
		prot_wr && write_enable_latch && !(write_protect_pin && protect_lock_enable)
		|=> {block_protect_bit1, block_protect_bit0} == $past(prot_bp)
		&& protect_lock_enable == $past(prot_lock))
		else $error("protect bits not loaded");
	a_rd_req_pulse: assert property (rd_req |=> !rd_req [*8])
		else $error("read pulses too close");
	a_fifo_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
		else $error("stalled head changed");
endmodule
bind eeprom_two_wire_slave eeprom_slave_chk eeprom_slave_chk_inst (
	.clk, .rst, .scl_pin, .sda_pin_o, .sda_pin_oe, .write_protect_pin, .wel_set,
	.prot_wr, .prot_bp, .prot_lock, .write_enable_latch, .protect_lock_enable,
	.block_protect_bit0, .block_protect_bit1, .prot_refused, .wr_valid, .wr_ready,
	.wr_data, .rd_req
);

// ==== verification/two_wire_master_model.sv ====
// behavioural two-wire bus master, open-drain data
`timescale 1ns/10ps
module two_wire_master_model (
	output logic      scl_o, // clock, stands high between frames
	output logic      sda_o, // 0 pulls low, 1 releases
	input  wire logic sda_i  // resolved line
);
	localparam realtime Q = 31.25;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// only this side starts frames and makes the clock
	task automatic start_bit();
		sda_o = 1'b1;
		#(Q);
		scl_o = 1'b1;
		#(Q);
		sda_o = 1'b0;
		#(Q);
		scl_o = 1'b0;
		#(Q);
	endtask
	task automatic stop_bit();
		sda_o = 1'b0; // slave has let go by now
		#(Q);
		scl_o = 1'b1;
		#(Q);
		sda_o = 1'b1;
		#(Q);
	endtask
	task automatic bit_cycle(input logic b, output logic s);
		sda_o = b;
		#(Q);
		scl_o = 1'b1;
		#(Q);
		s = sda_i;
		#(Q);
		scl_o = 1'b0;
		#(Q);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
		output logic lvl);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(tx[i], rx[i]);
		end
		bit_cycle(ack, lvl);
	endtask
endmodule

// ==== verification/test_eeprom_two_wire_slave.sv ====
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module test_eeprom_two_wire_slave;
	logic        clk, rst, scl_pin, sda_m, sda_pin_o, sda_pin_oe, nv_busy, lvl;
	logic        select_pin_0, select_pin_1, select_pin_2, write_protect_pin, hold;
	logic        wel_set, wel_clr, prot_wr, prot_lock, prot_refused, rd_req;
	logic        write_enable_latch, protect_lock_enable, link_active, wr_dropped;
	logic        block_protect_bit0, block_protect_bit1, wr_valid, wr_ready;
	logic [1:0]  prot_bp;
	logic [4:0]  wr_byte;
	logic [7:0]  wr_page, wr_data, rd_data, adr, d, rx;
	logic [12:0] rd_addr, a;
	logic [20:0] exp_q[$];
	logic [20:0] exp_w;
	logic [31:0] seed;
	wire         sda_pin_i;
	int          miscompares, checks_done, drops, refusals;
	assign sda_pin_i = sda_m & ~sda_pin_oe; // pulled-up wire
	assign rd_data = rd_addr[7:0] ^ rd_addr[12:5];
	eeprom_two_wire_slave eeprom_two_wire_slave_inst (.*);
	two_wire_master_model master (.scl_o(scl_pin), .sda_o(sda_m), .sda_i(sda_pin_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge clk) begin
		seed = lfsr(seed);
		wr_ready <= !hold && seed[0];
	end
	always @(posedge clk) begin
		drops += wr_dropped;
		refusals += prot_refused;
		if (wr_valid && wr_ready) begin
			`CHK(exp_q.size() > 0, 1'b1)
			// pop once; the compare macro reads its operands twice
			exp_w = exp_q.pop_front();
			`CHK({wr_page, wr_byte, wr_data}, exp_w)
		end
	end
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wbyte(input logic [7:0] b, input logic ack);
		master.xfer(b, 1'b1, rx, lvl);
		`CHK(lvl, !ack)
	endtask
	task automatic probe(input logic [7:0] b, input logic ack);
		master.start_bit();
		wbyte(b, ack);
		master.stop_bit();
	endtask
	task automatic hdr(input logic [7:0] hi, input logic [7:0] lo);
		master.start_bit();
		wbyte(adr, 1'b1);
		wbyte(hi, 1'b1);
		wbyte(lo, 1'b1);
	endtask
	task automatic latch(input logic set);
		@(negedge clk) {wel_set, wel_clr} = {set, !set};
		@(negedge clk) {wel_set, wel_clr} = 2'h0;
	endtask
	task automatic prot(input logic [1:0] bp, input logic lk, input int refs);
		@(negedge clk) {prot_wr, prot_lock, prot_bp} = {1'b1, lk, bp};
		@(negedge clk) prot_wr = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(refusals, refs)
	endtask
	initial begin
		seed = 32'h7E725740;
		{rst, hold, nv_busy, write_protect_pin} = 4'hC;
		{wel_set, wel_clr, prot_wr, prot_lock, prot_bp} = 5'h00;
		{select_pin_2, select_pin_1, select_pin_0} = seed[3:1];
		adr = {eeprom_slave_pkg::DEV_TYPE_CODE, seed[3:1], 1'b0};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		probe(adr ^ 8'h50, 1'b0);
		probe(adr ^ 8'h0E, 1'b0);
		@(negedge clk) nv_busy = 1'b1;
		probe(adr | 8'h01, 1'b0);
		@(negedge clk) nv_busy = 1'b0;
		probe(adr, 1'b1);
		$display("addressing done");
		hdr(8'h13, 8'hBE);
		wbyte(8'h5A, 1'b1);
		master.stop_bit();
		`CHK(drops, 1)
		latch(1'b1);
		hdr(8'h13, 8'hBE);
		for (int i = 0; i < 9; i++) begin
			d = seed[7:0];
			if (i < 8) exp_q.push_back({8'h9D, 5'(30 + i), d});
			wbyte(d, i < 8);
		end
		master.stop_bit();
		@(negedge clk) hold = 1'b0;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk);
		`CHK(exp_q.size(), 0)
		$display("fifo done");
		hdr(8'h1F, 8'hFE);
		master.start_bit();
		wbyte(adr | 8'h01, 1'b1);
		for (int i = 0; i < 3; i++) begin
			a = 13'h1FFE + 13'(i);
			master.xfer(8'hFF, i == 2, rx, lvl);
			`CHK(rx, a[7:0] ^ a[12:5])
			`CHK(lvl, i == 2)
			`CHK(link_active, i < 2)
		end
		master.stop_bit();
		$display("read done");
		for (int c = 0; c < 4; c++) begin
			prot(2'(c), 1'b0, 0);
			`CHK({block_protect_bit1, block_protect_bit0}, 2'(c))
			// one write below the top quarter, one inside it
			for (int k = 0; k < 2; k++) begin
				d = seed[7:0];
				if (c < 2 - k) exp_q.push_back({(k == 1) ? 13'h1FFE : 13'h13BE, d});
				hdr((k == 1) ? 8'h1F : 8'h13, (k == 1) ? 8'hFE : 8'hBE);
				wbyte(d, 1'b1);
				master.stop_bit();
			end
		end
		`CHK(drops, 6)
		@(negedge clk) write_protect_pin = 1'b1;
		prot(eeprom_slave_pkg::BP_ALL, 1'b1, 0);
		prot(eeprom_slave_pkg::BP_NONE, 1'b0, 1);
		`CHK({protect_lock_enable, block_protect_bit1, block_protect_bit0}, 3'h7)
		hdr(8'h13, 8'hBE);
		wbyte(8'hA5, 1'b1);
		master.stop_bit();
		`CHK(drops, 7)
		@(negedge clk) write_protect_pin = 1'b0;
		latch(1'b0);
		`CHK(write_enable_latch, 1'b0)
		prot(eeprom_slave_pkg::BP_NONE, 1'b0, 2);
		`CHK(exp_q.size(), 0)
		$display("protect done");
		test_done();
	end
	initial begin
		#400000;
		miscompares++;
		test_done();
	end
endmodule
